// *** pci_command_status_regs_test.sv ***
`timescale 1ns/1ns
module pci_command_status_regs_test;
   logic        sys_clk_in   = 1'b0;
   logic        rst_in       = 1'b1;
   logic        cfg_rd_in    = 1'b0;
   logic        cfg_wr_in    = 1'b0;
   logic [7:0]  cfg_addr_in  = 8'h00;
   logic [1:0]  cfg_be_in    = 2'h0;
   logic [15:0] cfg_wdata_in = 16'h0000;
   logic        strap        = 1'b0;
   logic        ta_req       = 1'b0;
   logic        ma_req       = 1'b0;
   logic [15:0] cfg_rdata_out;
   logic [15:0] command_out;
   logic [15:0] rd;
   logic [15:0] wd;
   logic        cfg_ack_out;
   logic        b2b_enable_out;
   logic        target_abort;
   logic        master_abort;
   int          seed         = 32'hcfb2;
   int          bad_count    = 0;
   int          checks_done  = 0;

   initial begin
      forever #50 sys_clk_in = ~sys_clk_in;
   end

   pcisr_regs uut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .cfg_rd_in(cfg_rd_in),
      .cfg_wr_in(cfg_wr_in), .cfg_addr_in(cfg_addr_in), .cfg_be_in(cfg_be_in),
      .cfg_wdata_in(cfg_wdata_in), .cfg_rdata_out(cfg_rdata_out), .cfg_ack_out(cfg_ack_out),
      .timing_strap_pin_in(strap), .target_abort_in(target_abort),
      .master_abort_in(master_abort), .b2b_enable_out(b2b_enable_out),
      .command_out(command_out));
   pcisr_engine_model engine (.sys_clk_in(sys_clk_in), .ta_req_in(ta_req), .ma_req_in(ma_req),
      .target_abort_out(target_abort), .master_abort_out(master_abort));

   function automatic logic [15:0] exp_sts(input logic s, input logic ta, input logic ma);
      return {3'h0, ma, ta, s ? 2'h2 : 2'h1, 9'h080};
   endfunction : exp_sts

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // one access; the answer is always registered one cycle after the request
   task automatic access(input logic wr, input logic [7:0] a, input logic [1:0] be,
                         input logic [15:0] d);
      @(negedge sys_clk_in);
      cfg_wr_in    = wr;
      cfg_rd_in    = ~wr;
      cfg_addr_in  = a;
      cfg_be_in    = be;
      cfg_wdata_in = d;
      @(negedge sys_clk_in);
      cfg_wr_in = 1'b0;
      cfg_rd_in = 1'b0;
      chk({15'h0, cfg_ack_out}, 16'h0001);
      rd = cfg_rdata_out;
   endtask : access

   task automatic pulse(input logic t);
      @(negedge sys_clk_in);
      ta_req = t;
      ma_req = ~t;
      @(negedge sys_clk_in);
      ta_req = 1'b0;
      ma_req = 1'b0;
   endtask : pulse

   task automatic do_reset(input logic s);
      rst_in = 1'b1;
      strap  = s;
      repeat (4) @(negedge sys_clk_in);
      rst_in = 1'b0;
      // the pin may move once reset is gone; the readback must not
      strap  = ~s;
      access(1'b0, pcisr_pkg::STS_OFS, 2'h3, 16'h0);
      chk(rd, exp_sts(s, 1'b0, 1'b0));
      access(1'b0, pcisr_pkg::STRAP_OFS, 2'h3, 16'h0);
      chk(rd, {15'h0, s});
      access(1'b0, pcisr_pkg::CMD_OFS, 2'h3, 16'h0);
      chk(rd, 16'h00a0);
      chk({15'h0, b2b_enable_out}, 16'h0000);
   endtask : do_reset

   task automatic test_done;
      if (bad_count == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : test_done

   initial begin
      do_reset(1'b0);
      for (int i = 0; i < 12; i++) begin
         wd = (i == 0) ? 16'hffff : (i == 1) ? 16'hfdff : 16'($random(seed));
         access(1'b1, pcisr_pkg::CMD_OFS, 2'h3, wd);
         chk(command_out, wd & 16'h02ff);
         chk({15'h0, b2b_enable_out}, {15'h0, wd[9]});
         access(1'b0, pcisr_pkg::CMD_OFS, 2'h3, 16'h0);
         chk(rd, wd & 16'h02ff);
      end
      // ones written to an idle status must not set anything
      access(1'b1, pcisr_pkg::STS_OFS, 2'h3, 16'hffff);
      access(1'b0, pcisr_pkg::STS_OFS, 2'h3, 16'h0);
      chk(rd, exp_sts(1'b0, 1'b0, 1'b0));
      pulse(1'b1);
      pulse(1'b0);
      access(1'b0, pcisr_pkg::STS_OFS, 2'h3, 16'h0);
      chk(rd, exp_sts(1'b0, 1'b1, 1'b1));
      access(1'b1, pcisr_pkg::STS_OFS, 2'h1, 16'h1800);
      access(1'b0, pcisr_pkg::STS_OFS, 2'h3, 16'h0);
      chk(rd, exp_sts(1'b0, 1'b1, 1'b1));
      access(1'b1, pcisr_pkg::STS_OFS, 2'h2, 16'h0800);
      access(1'b0, pcisr_pkg::STS_OFS, 2'h3, 16'h0);
      chk(rd, exp_sts(1'b0, 1'b0, 1'b1));
      access(1'b1, pcisr_pkg::STS_OFS, 2'h2, 16'h1000);
      access(1'b0, pcisr_pkg::STS_OFS, 2'h3, 16'h0);
      chk(rd, exp_sts(1'b0, 1'b0, 1'b0));
      // abort arriving in the very cycle of its clear: the set must win
      fork
         pulse(1'b1);
         begin
            @(negedge sys_clk_in);
            access(1'b1, pcisr_pkg::STS_OFS, 2'h2, 16'h0800);
         end
      join
      access(1'b0, pcisr_pkg::STS_OFS, 2'h3, 16'h0);
      chk(rd, exp_sts(1'b0, 1'b1, 1'b0));
      access(1'b0, 8'h10, 2'h3, 16'h0);
      chk(rd, 16'h0000);
      do_reset(1'b1);
      test_done();
   end
endmodule : pci_command_status_regs_test

// *** pcisr_engine_model.sv ***
`timescale 1ns/1ns
// master engine stand-in: reports abort endings of its own transactions
module pcisr_engine_model (
   // clock
   input  wire logic sys_clk_in,
   // requests from the bench
   input  wire logic ta_req_in,
   input  wire logic ma_req_in,
   // event pulses to the registers
   output logic      target_abort_out,
   output logic      master_abort_out
);
   initial begin
      target_abort_out = 1'b0;
      master_abort_out = 1'b0;
   end
   // registered on the rising edge; the non-blocking update keeps the pulse free of races
   always @(posedge sys_clk_in) begin
      target_abort_out <= ta_req_in;
      master_abort_out <= ma_req_in;
   end
endmodule : pcisr_engine_model

// *** pcisr_pkg.sv ***
package pcisr_pkg;
   // configuration byte offsets of the registers
   localparam logic [7:0]  CMD_OFS        = 8'h04;
   localparam logic [7:0]  STS_OFS        = 8'h06;
   localparam logic [7:0]  STRAP_OFS      = 8'h49;
   // command register
   localparam logic [15:0] CMD_RST        = 16'h00a0;
   localparam logic [15:0] CMD_WMASK      = 16'h02ff;
   localparam int          CMD_B2B_BIT    = 9;
   // status register fields
   localparam int          STS_FB2B_BIT   = 7;
   localparam int          STS_DEVSEL_LO  = 9;
   localparam int          STS_TABORT_BIT = 11;
   localparam int          STS_MABORT_BIT = 12;
   localparam logic [1:0]  DEVSEL_FAST    = 2'h0;
   localparam logic [1:0]  DEVSEL_MEDIUM  = 2'h1;
   localparam logic [1:0]  DEVSEL_SLOW    = 2'h2;
   localparam logic [15:0] STS_RESERVED   = 16'he17f;
   // strap readback
   localparam int          STRAP_BIT      = 0;
   localparam logic        STRAP_RST      = 1'b0;
endpackage : pcisr_pkg

// *** pcisr_regs.sv ***
// Notes on behaviour
// - Command bit 9 set lets the master issue back-to-back cycles to one target, clear forbids it.
// - The command register resets to 00a0h with bit 8 and bits 15 to 10 reserved.
// - Status reads return contents, writes clear bits 12 and 11 written with one and never set a bit.
// - Status bit 7 is read-only and always reads one.
// - Status bits 10:9 are read-only timing, strap low gives 01 and strap high gives 10.
// - The strap level sampled during reset reads back in bit 0 of the strap readback register.
// - Status bit 11 sets whenever a master transaction ends in target-abort.
// - Status bit 12 sets whenever a master transaction ends abnormally in master-abort.
// - Status bits 6 to 0 and bit 8 are reserved with no function.
`timescale 1ns/1ns
module pcisr_regs (
   // clock and reset
   input  wire logic        sys_clk_in,
   input  wire logic        rst_in,
   // configuration access
   input  wire logic        cfg_rd_in,
   input  wire logic        cfg_wr_in,
   input  wire logic [7:0]  cfg_addr_in,
   input  wire logic [1:0]  cfg_be_in,
   input  wire logic [15:0] cfg_wdata_in,
   output logic [15:0]      cfg_rdata_out,
   output logic             cfg_ack_out,
   // strap pin
   input  wire logic        timing_strap_pin_in,
   // master engine events
   input  wire logic        target_abort_in,
   input  wire logic        master_abort_in,
   // controls to the master engine
   output logic             b2b_enable_out,
   output logic [15:0]      command_out
);
   logic [15:0] pci_command_register_ff;
   logic [15:0] nxt_command;
   logic        strap_meta_ff;
   logic        strap_sync_ff;
   logic        strap_readback_register_ff;
   logic        tabort_flag;
   logic        mabort_flag;
   logic [15:0] pci_status_register;
   logic [15:0] byte_mask;
   logic        sts_wr;
   logic [15:0] nxt_rdata;

   assign byte_mask = {{8{cfg_be_in[1]}}, {8{cfg_be_in[0]}}};
   assign sts_wr    = cfg_wr_in && (cfg_addr_in == pcisr_pkg::STS_OFS);

   // strap pin is asynchronous to the bus clock
   always_ff @(posedge sys_clk_in) begin
      strap_meta_ff <= timing_strap_pin_in;
      strap_sync_ff <= strap_meta_ff;
   end

   // keep sampling while reset is held; the last level before release sticks
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         strap_readback_register_ff <= strap_sync_ff;
      end
   end

   always_comb begin
      nxt_command = pci_command_register_ff;
      if (cfg_wr_in && (cfg_addr_in == pcisr_pkg::CMD_OFS)) begin
         nxt_command = (pci_command_register_ff & ~(byte_mask & pcisr_pkg::CMD_WMASK))
                     | (cfg_wdata_in & byte_mask & pcisr_pkg::CMD_WMASK);
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         pci_command_register_ff <= pcisr_pkg::CMD_RST;
      end else begin
         pci_command_register_ff <= nxt_command;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         b2b_enable_out <= pcisr_pkg::CMD_RST[pcisr_pkg::CMD_B2B_BIT];
         command_out    <= pcisr_pkg::CMD_RST;
      end else begin
         b2b_enable_out <= nxt_command[pcisr_pkg::CMD_B2B_BIT];
         command_out    <= nxt_command;
      end
   end

   // abort flags: clear needs the high byte enabled and a one written
   pcisr_w1c_bit u_tabort (
      .sys_clk_in (sys_clk_in),
      .rst_in     (rst_in),
      .set_in     (target_abort_in),
      .clr_in     (sts_wr && cfg_be_in[1] && cfg_wdata_in[pcisr_pkg::STS_TABORT_BIT]),
      .flag_out   (tabort_flag)
   );

   pcisr_w1c_bit u_mabort (
      .sys_clk_in (sys_clk_in),
      .rst_in     (rst_in),
      .set_in     (master_abort_in),
      .clr_in     (sts_wr && cfg_be_in[1] && cfg_wdata_in[pcisr_pkg::STS_MABORT_BIT]),
      .flag_out   (mabort_flag)
   );

   always_comb begin
      pci_status_register = 16'h0000;
      pci_status_register[pcisr_pkg::STS_FB2B_BIT] = 1'b1;
      pci_status_register[pcisr_pkg::STS_DEVSEL_LO +: 2] =
         strap_readback_register_ff ? pcisr_pkg::DEVSEL_SLOW : pcisr_pkg::DEVSEL_MEDIUM;
      pci_status_register[pcisr_pkg::STS_TABORT_BIT] = tabort_flag;
      pci_status_register[pcisr_pkg::STS_MABORT_BIT] = mabort_flag;
   end

   // unmapped offsets read zero
   always_comb begin
      case (cfg_addr_in)
         pcisr_pkg::CMD_OFS:   nxt_rdata = pci_command_register_ff;
         pcisr_pkg::STS_OFS:   nxt_rdata = pci_status_register;
         pcisr_pkg::STRAP_OFS: nxt_rdata = {15'h0000, strap_readback_register_ff};
         default:              nxt_rdata = 16'h0000;
      endcase
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         cfg_rdata_out <= 16'h0000;
         cfg_ack_out   <= 1'b0;
      end else begin
         cfg_ack_out <= cfg_rd_in || cfg_wr_in;
         if (cfg_rd_in) begin
            cfg_rdata_out <= nxt_rdata;
         end
      end
   end

   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);

   sequence s_cmd_write;
      cfg_wr_in && cfg_be_in[1] && (cfg_addr_in == pcisr_pkg::CMD_OFS);
   endsequence

   sequence s_sts_read;
      cfg_rd_in && !cfg_wr_in && (cfg_addr_in == pcisr_pkg::STS_OFS);
   endsequence

   property p_b2b_follows_write;
      logic v;
      (s_cmd_write, v = cfg_wdata_in[9]) |=> (b2b_enable_out == v) && command_out[9] == v;
   endproperty
   a_b2b_follows_write: assert property (p_b2b_follows_write) else $error("b2b enable wrong");

   property p_cmd_reset;
      @(posedge sys_clk_in) $fell(rst_in) |-> pci_command_register_ff == pcisr_pkg::CMD_RST
         && command_out == pcisr_pkg::CMD_RST;
   endproperty
   a_cmd_reset: assert property (p_cmd_reset) else $error("command reset value wrong");

   property p_sts_clear;
      sts_wr && cfg_be_in[1] && cfg_wdata_in[11] && !target_abort_in |=> !tabort_flag;
   endproperty
   a_sts_clear: assert property (p_sts_clear) else $error("status bit not cleared");

   property p_sts_no_set;
      // neither flag may rise after a cycle with no event at all, whatever the bus writes
      !target_abort_in && !master_abort_in
         |=> !$rose(tabort_flag) && !$rose(mabort_flag);
   endproperty
   a_sts_no_set: assert property (p_sts_no_set) else $error("status bit set by write");

   property p_fb2b_read;
      s_sts_read |=> cfg_ack_out && cfg_rdata_out[7];
   endproperty
   a_fb2b_read: assert property (p_fb2b_read) else $error("fast b2b bit not one");

   property p_devsel;
      s_sts_read |=> cfg_rdata_out[10:9] == (strap_readback_register_ff ? 2'h2 : 2'h1);
   endproperty
   a_devsel: assert property (p_devsel) else $error("devsel timing wrong");

   property p_strap_hold;
      !rst_in |=> $stable(strap_readback_register_ff);
   endproperty
   a_strap_hold: assert property (p_strap_hold) else $error("strap changed after reset");

   property p_tabort;
      // the flag stays up unless a status write came in the cycle after the set
      target_abort_in |=> tabort_flag ##1 (tabort_flag || $past(sts_wr));
   endproperty
   a_tabort: assert property (p_tabort) else $error("target abort not flagged");

   property p_mabort;
      master_abort_in |=> mabort_flag;
   endproperty
   a_mabort: assert property (p_mabort) else $error("master abort not flagged");

   property p_reserved_zero;
      s_sts_read |=> (cfg_rdata_out & pcisr_pkg::STS_RESERVED) == 16'h0000;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits nonzero");

   property p_cmd_reserved;
      s_cmd_write |=> (pci_command_register_ff & 16'hfd00) == 16'h0000;
   endproperty
   a_cmd_reserved: assert property (p_cmd_reserved) else $error("command reserved set");

   property p_sts_read_data;
      s_sts_read |=> cfg_rdata_out == $past(pci_status_register);
   endproperty
   a_sts_read_data: assert property (p_sts_read_data) else $error("status read data wrong");

   property p_strap_read;
      cfg_rd_in && (cfg_addr_in == pcisr_pkg::STRAP_OFS)
         |=> cfg_rdata_out == {15'h0000, $past(strap_readback_register_ff)};
   endproperty
   a_strap_read: assert property (p_strap_read) else $error("strap readback wrong");

   property p_b2b_hold;
      !(cfg_wr_in && (cfg_addr_in == pcisr_pkg::CMD_OFS)) |=> $stable(b2b_enable_out);
   endproperty
   a_b2b_hold: assert property (p_b2b_hold) else $error("b2b enable moved alone");

   property p_unmapped_zero;
      cfg_rd_in && (cfg_addr_in != pcisr_pkg::CMD_OFS) && (cfg_addr_in != pcisr_pkg::STS_OFS)
         && (cfg_addr_in != pcisr_pkg::STRAP_OFS) |=> cfg_rdata_out == 16'h0000;
   endproperty
   a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read nonzero");
endmodule : pcisr_regs

// *** pcisr_w1c_bit.sv ***
`timescale 1ns/1ns
// sticky flag: hardware sets it, a one written by software clears it
module pcisr_w1c_bit (
   // clock and reset
   input  wire logic sys_clk_in,
   input  wire logic rst_in,
   // set and clear
   input  wire logic set_in,
   input  wire logic clr_in,
   // flag
   output logic      flag_out
);
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         flag_out <= 1'b0;
      end else if (set_in) begin
         // a set in the clearing cycle must not be lost
         flag_out <= 1'b1;
      end else if (clr_in) begin
         flag_out <= 1'b0;
      end
   end
endmodule : pcisr_w1c_bit
